// *** hdl/two_wire_map.svh ***
// constants of the simple two-wire master: timing, bit counts, reset values
// assumes inclusion by both design files through its bare name
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH
// Functional notes
// - the channel is only ever the bus master, driving a clock line and a data line.
// - only master transmit and master receive exist, with a single master on the link.
// - every byte on the link is exactly eight bits, in both directions.
// - an address byte carries the target address in its upper seven bits and read/write in bit 0.
// - the master drives the acknowledge after received bytes and samples it after sent bytes.
// - start and stop are produced only when software commands them, never automatically.
// - the start and stop line timing comes from the quarter divider in hardware; software only issues the command.
// - each finished transfer raises a transfer-end event, and ack or overrun errors set flags.
// - with the channel output enable cleared, no acknowledge is driven for a received byte.
// - there is no slave operation; the channel never answers another master's address.
// - arbitration loss and clock stretching are not detected; clocking just continues.
`define CLK_FREQ_KHZ 40000
`define SCL_FREQ_KHZ 400
`define QUARTER_CYCLES ((`CLK_FREQ_KHZ) / ((`SCL_FREQ_KHZ) * 4))
`define BYTE_BITS 8
`define BIT_CNT_W 4
`define LAST_BIT_IDX 4'h8
`define LAST_QUARTER 2'h3
`define SAMPLE_QUARTER 2'h2
`define RISE_QUARTER 2'h1
`define RST_BYTE 8'h00
`endif

// *** hdl/two_wire_pkg.sv ***
// types shared by the two-wire master design files
// assumes nothing beyond the timing header
package two_wire_pkg;
    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP = 2'h1,
        OP_WRITE = 2'h2,
        OP_READ = 2'h3
    } cmd_op_e;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_BYTE = 4'h4,
        ST_STOP = 4'h8
    } link_state_e;
endpackage

// *** hdl/quarter_tick.sv ***
// divider giving a one-cycle enable pulse every quarter of an scl period
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "two_wire_map.svh"
module quarter_tick #(
    parameter int unsigned DIV = `QUARTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic run_i,
    output logic tick_o
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_ff;

    if (DIV < 2)
    begin
        $error("quarter_tick: DIV must be at least 2");
    end

    // counter idles at zero so the first quarter of a command is full length
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || !run_i)
            cnt_ff <= '0;
        else if (cnt_ff == CW'(DIV - 1))
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + 1'b1;
    end

    assign tick_o = run_i && (cnt_ff == CW'(DIV - 1));

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick_o |=> !tick_o)
        else $error("quarter tick repeated on adjacent cycles");
endmodule

// *** hdl/simple_two_wire_master.sv ***
// single-master two-wire controller: start, stop, byte write and byte read on command
// assumes open-drain pads outside and one slave on the link; no register bus
`timescale 1ns/1ps
`include "two_wire_map.svh"
module simple_two_wire_master
    import two_wire_pkg::*;
#(
    parameter int unsigned QUARTER_DIV = `QUARTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [1:0] cmd_op_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    input wire logic channel_output_enable_bit_i,
    output logic done_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_read_i,
    output logic ack_err_o,
    output logic overrun_err_o,
    input wire logic err_clear_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    link_state_e state_ff;
    logic [1:0] quarter_ff;
    logic [`BIT_CNT_W-1:0] bit_ff;
    logic [7:0] shift_ff;
    logic is_read_ff;
    logic ack_drive_ff;
    logic scl_level_ff;
    logic sda_level_ff;
    logic sda_meta_ff;
    logic sda_sync_ff;
    logic done_ff;
    logic [7:0] rx_data_ff;
    logic rx_valid_ff;
    logic ack_err_ff;
    logic overrun_ff;
    logic [3:0] scl_rise_cnt_ff;
    logic tick;
    logic run;
    logic end_quarter;
    logic byte_end;
    logic rx_byte_end;
    logic tx_ack_high;
    logic nxt_sda;
    logic nxt_scl;

    assign run = (state_ff != ST_IDLE);
    assign end_quarter = tick && (quarter_ff == `LAST_QUARTER);
    assign byte_end = (state_ff == ST_BYTE) && end_quarter && (bit_ff == `LAST_BIT_IDX);
    assign rx_byte_end = byte_end && is_read_ff;

    quarter_tick #(
        .DIV(QUARTER_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .run_i(run),
        .tick_o(tick)
    );

    // two flops before the data line is looked at
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            sda_meta_ff <= 1'b1;
            sda_sync_ff <= 1'b1;
        end
        else
        begin
            sda_meta_ff <= sda_i;
            sda_sync_ff <= sda_meta_ff;
        end
    end

    // command acceptance and sequencing; start/stop only on explicit command
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_ff <= ST_IDLE;
            quarter_ff <= 2'h0;
            bit_ff <= '0;
            is_read_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    quarter_ff <= 2'h0;
                    bit_ff <= '0;
                    if (cmd_valid_i)
                    begin
                        is_read_ff <= (cmd_op_i == OP_READ);
                        ack_drive_ff <= channel_output_enable_bit_i;
                        case (cmd_op_i)
                            OP_START: state_ff <= ST_START;
                            OP_STOP: state_ff <= ST_STOP;
                            default: state_ff <= ST_BYTE;
                        endcase
                    end
                end
                ST_START, ST_STOP:
                begin
                    if (tick)
                        quarter_ff <= quarter_ff + 2'h1;
                    if (end_quarter)
                        state_ff <= ST_IDLE;
                end
                ST_BYTE:
                begin
                    if (tick)
                        quarter_ff <= quarter_ff + 2'h1;
                    if (end_quarter)
                        bit_ff <= bit_ff + 1'b1;
                    // eight data bits then one acknowledge slot
                    if (byte_end)
                        state_ff <= ST_IDLE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // shift register: msb first; address byte is just data with r/w in bit 0
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            shift_ff <= `RST_BYTE;
        else if (state_ff == ST_IDLE && cmd_valid_i)
            shift_ff <= cmd_data_i;
        else if (state_ff == ST_BYTE && tick && quarter_ff == `SAMPLE_QUARTER
                 && bit_ff < `LAST_BIT_IDX)
            shift_ff <= {shift_ff[6:0], sda_sync_ff};
    end

    // line levels per quarter; no stretch or arbitration check, scl just runs
    always_comb
    begin
        // idle holds the lines so scl stays low between bytes of one transfer
        nxt_scl = scl_level_ff;
        nxt_sda = sda_level_ff;
        case (state_ff)
            ST_START:
            begin
                nxt_scl = (quarter_ff != `LAST_QUARTER);
                nxt_sda = (quarter_ff < `SAMPLE_QUARTER);
            end
            ST_STOP:
            begin
                nxt_scl = (quarter_ff != 2'h0);
                nxt_sda = (quarter_ff >= `SAMPLE_QUARTER);
            end
            ST_BYTE:
            begin
                nxt_scl = (quarter_ff == `RISE_QUARTER) || (quarter_ff == `SAMPLE_QUARTER);
                if (bit_ff == `LAST_BIT_IDX)
                    nxt_sda = is_read_ff ? !ack_drive_ff : 1'b1;
                else
                    nxt_sda = is_read_ff ? 1'b1 : shift_ff[7];
            end
            default:
            begin
                nxt_scl = scl_level_ff;
                nxt_sda = sda_level_ff;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            scl_level_ff <= 1'b1;
            sda_level_ff <= 1'b1;
        end
        else
        begin
            scl_level_ff <= nxt_scl;
            sda_level_ff <= nxt_sda;
        end
    end

    // open drain: only ever pull low, never answer as a slave
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = !scl_level_ff;
    assign sda_oe_o = !sda_level_ff;

    // transfer end event, one cycle per finished command
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            done_ff <= 1'b0;
        else
            done_ff <= run && end_quarter && (state_ff != ST_BYTE || byte_end);
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            rx_data_ff <= `RST_BYTE;
        else if (rx_byte_end)
            rx_data_ff <= shift_ff;
    end

    // a new byte outranks a read in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            rx_valid_ff <= 1'b0;
        else if (rx_byte_end)
            rx_valid_ff <= 1'b1;
        else if (rx_read_i)
            rx_valid_ff <= 1'b0;
    end

    assign tx_ack_high = (state_ff == ST_BYTE) && !is_read_ff && tick
        && quarter_ff == `SAMPLE_QUARTER && bit_ff == `LAST_BIT_IDX;

    // error flags: set wins over clear
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            ack_err_ff <= 1'b0;
        else if (tx_ack_high && sda_sync_ff)
            ack_err_ff <= 1'b1;
        else if (err_clear_i)
            ack_err_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            overrun_ff <= 1'b0;
        else if (rx_byte_end && rx_valid_ff && !rx_read_i)
            overrun_ff <= 1'b1;
        else if (err_clear_i)
            overrun_ff <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!resetn_i || state_ff != ST_BYTE)
            scl_rise_cnt_ff <= '0;
        else if (!scl_level_ff && nxt_scl)
            scl_rise_cnt_ff <= scl_rise_cnt_ff + 1'b1;
    end

    assign cmd_ready_o = (state_ff == ST_IDLE);
    assign done_o = done_ff;
    assign rx_data_o = rx_data_ff;
    assign rx_valid_o = rx_valid_ff;
    assign ack_err_o = ack_err_ff;
    assign overrun_err_o = overrun_ff;

    a_start_only_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_ff == ST_START |-> $past(state_ff) == ST_START
            || ($past(cmd_valid_i) && $past(cmd_op_i) == OP_START))
        else $error("start produced without a start command");
    a_stop_only_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(state_ff == ST_STOP) |-> $past(cmd_op_i) == OP_STOP)
        else $error("stop produced without a stop command");
    a_nine_clocks: assert property (@(posedge clk_i) disable iff (!resetn_i)
        byte_end |-> scl_rise_cnt_ff == 4'h9)
        else $error("byte ended after wrong bit count");
    a_ack_err_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tx_ack_high && sda_sync_ff |=> ack_err_ff)
        else $error("missing ack not flagged");
    a_no_ack_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_ff == ST_BYTE && is_read_ff && !ack_drive_ff && bit_ff == 4'h8
            |=> !sda_oe_o)
        else $error("ack driven with output enable cleared");
    a_overrun_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
        rx_byte_end && rx_valid_ff && !rx_read_i |=> overrun_ff && rx_valid_ff)
        else $error("overrun not flagged");
    a_done_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
        run && end_quarter && state_ff != ST_BYTE |=> done_o ##1 !done_o)
        else $error("transfer end pulse wrong");
    a_start_shape: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state_ff == ST_START && quarter_ff == 2'h2 && tick |=> !sda_level_ff && scl_level_ff)
        else $error("start condition shape wrong");
    a_ready_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
        else $error("command not taken");
endmodule

// *** testbench/two_wire_slave_model.sv ***
// behavioural single slave on the two-wire link: acks writes, serves read bytes
// assumes the bench resolves the open-drain lines with pull-ups
`timescale 1ns/1ps
module two_wire_slave_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_en_i,
    input wire logic [7:0] tx_byte_i,
    output logic sda_oe_o,
    output logic [7:0] last_rx_o,
    output logic last_ack_o
);
    int bit_n;
    logic first;
    logic rd;
    logic [7:0] sh;
    initial
    begin
        sda_oe_o = 1'b0;
        bit_n = 0;
        first = 1'b1;
        rd = 1'b0;
        sh = 8'h00;
        last_rx_o = 8'h00;
        last_ack_o = 1'b1;
    end
    // start seen as data falling while clock high
    always @(negedge sda_i)
    begin
        if (scl_i)
        begin
            bit_n = 0;
            first = 1'b1;
            rd = 1'b0;
        end
    end
    // msb first, the ninth rising edge carries the acknowledge
    always @(posedge scl_i)
    begin
        if (bit_n < 8)
            sh = {sh[6:0], sda_i};
        else
            last_ack_o = sda_i;
        bit_n++;
    end
    always @(negedge scl_i)
    begin
        if (bit_n == 9)
        begin
            bit_n = 0;
            first = 1'b0;
        end
        if (bit_n == 8)
        begin
            last_rx_o = sh;
            if (first)
                rd = sh[0];
            sda_oe_o = (first || !rd) && ack_en_i;
        end
        else if (bit_n < 8 && rd && !first)
            sda_oe_o = !tx_byte_i[7 - bit_n];
        else
            sda_oe_o = 1'b0;
    end
endmodule

// *** testbench/test_simple_two_wire_master.sv ***
// self-checking bench for the two-wire master against one slave model
// assumes pull-ups on both lines and a shortened quarter divider
`timescale 1ns/1ps
module test_simple_two_wire_master;
    import two_wire_pkg::*;
    localparam int Q = 2;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [7:0] cmd_data_i = 8'h00;
    logic channel_output_enable_bit_i = 1'b0;
    logic rx_read_i = 1'b0;
    logic err_clear_i = 1'b0;
    logic ack_en = 1'b1;
    logic [7:0] tx_byte = 8'h00;
    logic cmd_ready_o, done_o, rx_valid_o, ack_err_o, overrun_err_o;
    logic scl_oe_o, sda_oe_o, s_oe, s_ack, scl_o, sda_o;
    logic [7:0] rx_data_o, s_rx;
    wire scl_w = ~scl_oe_o;
    wire sda_w = ~(sda_oe_o | s_oe);
    int fail_count = 0;
    int n_tests = 0;
    always #12.5 clk_i = ~clk_i;
    simple_two_wire_master #(.QUARTER_DIV(Q)) i_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
        .channel_output_enable_bit_i(channel_output_enable_bit_i), .done_o(done_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_read_i(rx_read_i),
        .ack_err_o(ack_err_o), .overrun_err_o(overrun_err_o), .err_clear_i(err_clear_i),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .sda_i(sda_w)
    );
    two_wire_slave_model i_slave (
        .scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en), .tx_byte_i(tx_byte),
        .sda_oe_o(s_oe), .last_rx_o(s_rx), .last_ack_o(s_ack)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one command, then its transfer-end latency is checked
    task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic en);
        int n;
        @(posedge clk_i);
        cmd_op_i <= op;
        cmd_data_i <= d;
        channel_output_enable_bit_i <= en;
        cmd_valid_i <= 1'b1;
        n = 0;
        do
            @(posedge clk_i);
        while (cmd_ready_o !== 1'b1 && ++n < 100);
        cmd_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (done_o !== 1'b1 && n < 200);
        check(16'(n), op[1] ? 16'(36 * Q + 1) : 16'(4 * Q + 1));
    endtask
    task automatic pulse_read;
        @(posedge clk_i);
        rx_read_i <= 1'b1;
        @(posedge clk_i);
        rx_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic pulse_clear;
        @(posedge clk_i);
        err_clear_i <= 1'b1;
        @(posedge clk_i);
        err_clear_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic t_reset;
        check({cmd_ready_o, scl_oe_o, sda_oe_o, rx_valid_o}, 16'h8);
        check({ack_err_o, overrun_err_o, rx_data_o}, 16'h0);
        check({scl_o, sda_o}, 16'h0);
        $display("test reset done");
    endtask
    task automatic t_write_ack;
        ack_en <= 1'b1;
        cmd(OP_START, 8'h00, 1'b1);
        cmd(OP_WRITE, 8'ha4, 1'b1);
        check(s_rx, 8'ha4);
        cmd(OP_WRITE, 8'h5a, 1'b1);
        check(s_rx, 8'h5a);
        check(ack_err_o, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b1);
        // nothing further may appear on the lines without a command
        repeat (40) @(posedge clk_i);
        check({scl_oe_o, sda_oe_o, done_o, scl_w, sda_w}, 16'h3);
        $display("test write with ack done");
    endtask
    task automatic t_write_nack;
        ack_en <= 1'b0;
        cmd(OP_START, 8'h00, 1'b1);
        cmd(OP_WRITE, 8'h3c, 1'b1);
        check(ack_err_o, 1'b1);
        cmd(OP_STOP, 8'h00, 1'b1);
        check(ack_err_o, 1'b1);
        pulse_clear();
        check(ack_err_o, 1'b0);
        $display("test write without ack done");
    endtask
    task automatic t_read;
        ack_en <= 1'b1;
        tx_byte <= 8'hc3;
        cmd(OP_START, 8'h00, 1'b1);
        cmd(OP_WRITE, 8'ha5, 1'b1);
        cmd(OP_READ, 8'h00, 1'b1);
        check({rx_valid_o, rx_data_o}, 16'h1c3);
        check(s_ack, 1'b0);
        tx_byte <= 8'h81;
        // last byte with output disabled and the first byte still unread
        cmd(OP_READ, 8'h00, 1'b0);
        check(s_ack, 1'b1);
        check(overrun_err_o, 1'b1);
        check(rx_data_o, 8'h81);
        pulse_read();
        check(rx_valid_o, 1'b0);
        cmd(OP_STOP, 8'h00, 1'b1);
        pulse_clear();
        check(overrun_err_o, 1'b0);
        $display("test read done");
    endtask
    // whole run is about 570 cycles, so this span is generous
    initial
    begin
        #200000;
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        #1;
        t_reset();
        t_write_ack();
        t_write_nack();
        t_read();
        complete_run();
    end
endmodule
